// file: inc/timer_pkg.sv
// constants for the match/capture timer block
package timer_pkg;
	localparam int NUM_TIMERS = 4;
	localparam int NUM_MATCH = 4;
	localparam int NUM_CAPS = 2;
	localparam int NUM_DMA = 2;
	localparam int CW = 32;
	// register index, word address = index * 4 inside a timer
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_PRESC = 4'h1;
	localparam logic [3:0] REG_PCNT = 4'h2;
	localparam logic [3:0] REG_COUNT = 4'h3;
	localparam logic [3:0] REG_MCTL = 4'h4;
	localparam logic [3:0] REG_MATCH0 = 4'h5;
	localparam logic [3:0] REG_OUTCTL = 4'h9;
	localparam logic [3:0] REG_CAPCTL = 4'ha;
	localparam logic [3:0] REG_CAP0 = 4'hb;
	localparam logic [3:0] REG_STATUS = 4'hd;
	localparam logic [3:0] REG_MASK = 4'he;
	localparam logic [3:0] REG_DMACTL = 4'hf;
	// control fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_RST = 1;
	localparam int CTRL_EXT = 2;
	// match control: per channel 3 bits starting at 3*m
	localparam int MC_INT = 0;
	localparam int MC_RESET = 1;
	localparam int MC_STOP = 2;
	// output control: state in low bits, action 2 bits at ACT_POS+2*m
	localparam int ACT_POS = 4;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// capture control: per channel 3 bits starting at 3*c
	localparam int CC_RISE = 0;
	localparam int CC_FALL = 1;
	localparam int CC_INT = 2;
	// status / mask: match bits first, capture bits above
	localparam int ST_CAP = 4;
	// writable bits of each register
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0007;
	localparam logic [31:0] MCTL_WMASK = 32'h0000_0fff;
	localparam logic [31:0] OUTCTL_WMASK = 32'h0000_0fff;
	localparam logic [31:0] CAPCTL_WMASK = 32'h0000_003f;
	localparam logic [31:0] INT_WMASK = 32'h0000_003f;
	localparam logic [31:0] DMA_WMASK = 32'h0000_0003;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : timer_pkg

// file: design/timer_counter_match_capture.sv
// four 32-bit timer/counters with prescaler, match and capture
// What this block does
// [R01] four independent timers, own counter, prescaler, channels
// [R02] count system clock or external clock input
// [R03] programmable 32-bit prescaler ahead of counter
// [R04] four match values trigger configurable actions
// [R05] continuous match keeps counting, optional interrupt
// [R06] stop match halts counter, optional interrupt
// [R07] reset match zeroes counter, optional interrupt
// [R08] match outputs go low, high, toggle, hold
// [R09] two match channels issue DMA requests
// [R10] two capture channels latch count on edge
// [R11] capture interrupt under per-channel enable
// [R12] counter steps when prescale count hits limit
// [R13] match on equality; capture inputs synchronised first
module timer_counter_match_capture
	import timer_pkg::*;
(
	// clock, reset, enable
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CE,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// pins
	input wire logic [NUM_TIMERS-1:0] CNT_IN,
	input wire logic [NUM_TIMERS*NUM_CAPS-1:0] CAP_IN,
	output logic [NUM_TIMERS*NUM_MATCH-1:0] MAT_OUT,
	output logic [NUM_TIMERS*NUM_DMA-1:0] DMA_REQ,
	output logic IRQ
);
	// ==========================================================
	// state
	logic [31:0] ctrl [NUM_TIMERS];
	logic [31:0] presc [NUM_TIMERS];
	logic [31:0] pcnt [NUM_TIMERS];
	logic [31:0] count [NUM_TIMERS];
	logic [31:0] mctl [NUM_TIMERS];
	logic [31:0] match [NUM_TIMERS][NUM_MATCH];
	logic [31:0] outctl [NUM_TIMERS];
	logic [31:0] capctl [NUM_TIMERS];
	logic [31:0] cap [NUM_TIMERS][NUM_CAPS];
	logic [31:0] status [NUM_TIMERS];
	logic [31:0] mask [NUM_TIMERS];
	logic [31:0] dmactl [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] cnt_s1, cnt_s2, cnt_s3;
	logic [NUM_TIMERS*NUM_CAPS-1:0] cap_s1, cap_s2, cap_s3;
	logic [NUM_TIMERS*NUM_DMA-1:0] dma_req;
	logic irq;
	logic [31:0] rdata;

	logic [31:0] next_ctrl [NUM_TIMERS];
	logic [31:0] next_presc [NUM_TIMERS];
	logic [31:0] next_pcnt [NUM_TIMERS];
	logic [31:0] next_count [NUM_TIMERS];
	logic [31:0] next_mctl [NUM_TIMERS];
	logic [31:0] next_match [NUM_TIMERS][NUM_MATCH];
	logic [31:0] next_outctl [NUM_TIMERS];
	logic [31:0] next_capctl [NUM_TIMERS];
	logic [31:0] next_cap [NUM_TIMERS][NUM_CAPS];
	logic [31:0] next_status [NUM_TIMERS];
	logic [31:0] next_mask [NUM_TIMERS];
	logic [31:0] next_dmactl [NUM_TIMERS];
	logic [NUM_TIMERS*NUM_DMA-1:0] next_dma_req;
	logic next_irq;
	logic [31:0] next_rdata;

	// per-timer decode results
	logic [NUM_TIMERS-1:0] run;
	logic [NUM_TIMERS-1:0] src;
	logic [NUM_TIMERS-1:0] wrap;
	logic [NUM_MATCH-1:0] hit [NUM_TIMERS];
	logic [NUM_CAPS-1:0] cedge [NUM_TIMERS];

	logic [1:0] sel_t;
	logic [3:0] sel_r;
	assign sel_t = ADDR[7:6];
	assign sel_r = ADDR[5:2];

	// ==========================================================
	// helpers
	function automatic logic edge_hit(input logic now, input logic prev,
			input logic rise_en, input logic fall_en);
		edge_hit = (rise_en && now && !prev) || (fall_en && !now && prev);
	endfunction : edge_hit

	function automatic logic out_next(input logic cur, input logic [1:0] act);
		out_next = cur;
		case (act)
			ACT_LOW: out_next = 1'b0;
			ACT_HIGH: out_next = 1'b1;
			ACT_TOGGLE: out_next = !cur;
			default: out_next = cur;
		endcase
	endfunction : out_next

	function automatic logic [31:0] read_word(input logic [1:0] t,
			input logic [3:0] r);
		read_word = RST_WORD;
		if (r == REG_CTRL) begin
			read_word = ctrl[t];
		end else if (r == REG_PRESC) begin
			read_word = presc[t];
		end else if (r == REG_PCNT) begin
			read_word = pcnt[t];
		end else if (r == REG_COUNT) begin
			read_word = count[t];
		end else if (r == REG_MCTL) begin
			read_word = mctl[t];
		end else if (r >= REG_MATCH0 && r < REG_OUTCTL) begin
			read_word = match[t][2'(r - REG_MATCH0)];
		end else if (r == REG_OUTCTL) begin
			read_word = outctl[t];
		end else if (r == REG_CAPCTL) begin
			read_word = capctl[t];
		end else if (r >= REG_CAP0 && r < REG_STATUS) begin
			read_word = cap[t][1'(r - REG_CAP0)];
		end else if (r == REG_STATUS) begin
			read_word = status[t];
		end else if (r == REG_MASK) begin
			read_word = mask[t];
		end else begin
			read_word = dmactl[t];
		end
	endfunction : read_word

	// ==========================================================
	// next state
	always_comb begin
		next_ctrl = ctrl;
		next_presc = presc;
		next_pcnt = pcnt;
		next_count = count;
		next_mctl = mctl;
		next_match = match;
		next_outctl = outctl;
		next_capctl = capctl;
		next_cap = cap;
		next_status = status;
		next_mask = mask;
		next_dmactl = dmactl;
		next_dma_req = '0;
		next_rdata = RST_WORD;
		next_irq = 1'b0;
		for (int t = 0; t < NUM_TIMERS; t++) begin // [R01]
			// write-one-to-clear first so a same-cycle event wins
			if (WR && sel_t == 2'(t) && sel_r == REG_STATUS) begin
				next_status[t] = status[t] & ~(WDATA & INT_WMASK);
			end
			run[t] = ctrl[t][CTRL_EN] && !ctrl[t][CTRL_RST];
			src[t] = ctrl[t][CTRL_EXT] ? (cnt_s2[t] && !cnt_s3[t]) : 1'b1; // [R02]
			wrap[t] = run[t] && src[t] && (pcnt[t] == presc[t]); // [R12]
			if (run[t] && src[t]) begin
				next_pcnt[t] = wrap[t] ? RST_WORD : pcnt[t] + 32'h1; // [R03]
			end
			if (wrap[t]) begin
				next_count[t] = count[t] + 32'h1; // [R05]
			end
			for (int m = 0; m < NUM_MATCH; m++) begin
				hit[t][m] = wrap[t] && (count[t] == match[t][m]); // [R13]
				if (hit[t][m]) begin // [R04]
					if (mctl[t][3*m+MC_INT]) begin
						next_status[t][m] = 1'b1;
					end
					if (mctl[t][3*m+MC_RESET]) begin
						next_count[t] = RST_WORD; // [R07]
					end
					if (mctl[t][3*m+MC_STOP]) begin
						next_count[t] = count[t]; // [R06]
						next_pcnt[t] = pcnt[t];
						next_ctrl[t][CTRL_EN] = 1'b0;
					end
					next_outctl[t][m] = out_next(outctl[t][m],
						outctl[t][ACT_POS+2*m +: 2]); // [R08]
				end
			end
			// only the low channels own a request line
			for (int m = 0; m < NUM_DMA; m++) begin
				next_dma_req[t*NUM_DMA+m] = hit[t][m] && dmactl[t][m]; // [R09]
			end
			if (ctrl[t][CTRL_RST]) begin
				next_pcnt[t] = RST_WORD;
				next_count[t] = RST_WORD;
			end
			for (int c = 0; c < NUM_CAPS; c++) begin
				cedge[t][c] = edge_hit(cap_s2[t*NUM_CAPS+c],
					cap_s3[t*NUM_CAPS+c], capctl[t][3*c+CC_RISE],
					capctl[t][3*c+CC_FALL]); // [R13]
				if (cedge[t][c]) begin
					next_cap[t][c] = count[t]; // [R10]
					if (capctl[t][3*c+CC_INT]) begin
						next_status[t][ST_CAP+c] = 1'b1; // [R11]
					end
				end
			end
			// software writes land after the counting logic
			if (WR && sel_t == 2'(t)) begin
				if (sel_r == REG_CTRL) begin
					next_ctrl[t] = WDATA & CTRL_WMASK;
				end else if (sel_r == REG_PRESC) begin
					next_presc[t] = WDATA;
				end else if (sel_r == REG_PCNT) begin
					next_pcnt[t] = WDATA;
				end else if (sel_r == REG_COUNT) begin
					next_count[t] = WDATA;
				end else if (sel_r == REG_MCTL) begin
					next_mctl[t] = WDATA & MCTL_WMASK;
				end else if (sel_r >= REG_MATCH0 && sel_r < REG_OUTCTL) begin
					next_match[t][2'(sel_r - REG_MATCH0)] = WDATA;
				end else if (sel_r == REG_OUTCTL) begin
					next_outctl[t] = WDATA & OUTCTL_WMASK;
				end else if (sel_r == REG_CAPCTL) begin
					next_capctl[t] = WDATA & CAPCTL_WMASK;
				end else if (sel_r == REG_MASK) begin
					next_mask[t] = WDATA & INT_WMASK;
				end else if (sel_r == REG_DMACTL) begin
					next_dmactl[t] = WDATA & DMA_WMASK;
				end
			end
			next_irq = next_irq || |(next_status[t] & next_mask[t]);
		end
		if (RD) begin
			next_rdata = read_word(sel_t, sel_r);
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			for (int t = 0; t < NUM_TIMERS; t++) begin
				ctrl[t] <= RST_WORD;
				presc[t] <= RST_WORD;
				pcnt[t] <= RST_WORD;
				count[t] <= RST_WORD;
				mctl[t] <= RST_WORD;
				outctl[t] <= RST_WORD;
				capctl[t] <= RST_WORD;
				status[t] <= RST_WORD;
				mask[t] <= RST_WORD;
				dmactl[t] <= RST_WORD;
				for (int m = 0; m < NUM_MATCH; m++) begin
					match[t][m] <= RST_WORD;
				end
				for (int c = 0; c < NUM_CAPS; c++) begin
					cap[t][c] <= RST_WORD;
				end
			end
			cnt_s1 <= '0;
			cnt_s2 <= '0;
			cnt_s3 <= '0;
			cap_s1 <= '0;
			cap_s2 <= '0;
			cap_s3 <= '0;
			dma_req <= '0;
			irq <= 1'b0;
			rdata <= RST_WORD;
		end else if (CE) begin
			ctrl <= next_ctrl;
			presc <= next_presc;
			pcnt <= next_pcnt;
			count <= next_count;
			mctl <= next_mctl;
			match <= next_match;
			outctl <= next_outctl;
			capctl <= next_capctl;
			cap <= next_cap;
			status <= next_status;
			mask <= next_mask;
			dmactl <= next_dmactl;
			cnt_s1 <= CNT_IN;
			cnt_s2 <= cnt_s1;
			cnt_s3 <= cnt_s2;
			cap_s1 <= CAP_IN; // [R13]
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
			dma_req <= next_dma_req;
			irq <= next_irq;
			rdata <= next_rdata;
		end
	end

	always_comb begin
		for (int t = 0; t < NUM_TIMERS; t++) begin
			MAT_OUT[t*NUM_MATCH +: NUM_MATCH] = outctl[t][NUM_MATCH-1:0];
		end
	end
	assign DMA_REQ = dma_req;
	assign IRQ = irq;
	assign RDATA = rdata;

	// ==========================================================
	// assertions on timers 0 and 1
	property p_prescale;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && run[0] && src[0] && !wrap[0] && !ctrl[0][CTRL_RST]
		|=> count[0] == $past(count[0]) && pcnt[0] == $past(pcnt[0]) + 32'h1;
	endproperty
	a_prescale: assert property (p_prescale) // [R03]
		else $error("counter moved before prescale limit");

	property p_continue;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && wrap[0] && !(|hit[0]) && !ctrl[0][CTRL_RST]
		|=> count[0] == $past(count[0]) + 32'h1 && pcnt[0] == 32'h0;
	endproperty
	a_continue: assert property (p_continue) // [R12]
		else $error("counter did not step at prescale wrap");

	property p_reset;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && hit[0][1] && mctl[0][3+MC_RESET] && !mctl[0][3+MC_STOP]
		&& hit[0][3:2] == 2'h0 && !ctrl[0][CTRL_RST]
		|=> count[0] == 32'h0;
	endproperty
	a_reset: assert property (p_reset) // [R07]
		else $error("reset on match did not zero counter");

	property p_stop;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && hit[0][0] && mctl[0][MC_STOP]
		|=> !ctrl[0][CTRL_EN] && count[0] == $past(count[0]);
	endproperty
	a_stop: assert property (p_stop) // [R06]
		else $error("stop on match did not halt counter");

	property p_toggle;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && hit[0][0] && outctl[0][ACT_POS +: 2] == ACT_TOGGLE
		|=> MAT_OUT[0] != $past(MAT_OUT[0]);
	endproperty
	a_toggle: assert property (p_toggle) // [R08]
		else $error("match output did not toggle");

	property p_dma;
		@(posedge SYS_CLK) disable iff (RST)
		$rose(DMA_REQ[0]) |-> $past(hit[0][0]) && $past(dmactl[0][0])
			&& $past(CE);
	endproperty
	a_dma: assert property (p_dma) // [R09]
		else $error("dma request without enabled match");

	property p_capture;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && cedge[1][0] |=> cap[1][0] == $past(count[1]);
	endproperty
	a_capture: assert property (p_capture) // [R10]
		else $error("capture did not latch counter");

	property p_irq;
		@(posedge SYS_CLK) disable iff (RST)
		CE && !WR && cedge[1][0] && capctl[1][CC_INT] && mask[1][ST_CAP]
		|=> status[1][ST_CAP] && IRQ;
	endproperty
	a_irq: assert property (p_irq) // [R11]
		else $error("capture interrupt not raised");

	property p_sync;
		@(posedge SYS_CLK) disable iff (RST)
		CE && $past(CE) && $past(CE, 2) |-> cap_s2[2] == $past(CAP_IN[2], 2);
	endproperty
	a_sync: assert property (p_sync) // [R13]
		else $error("capture input not synchronised over two stages");
endmodule : timer_counter_match_capture

// file: tb/ext_pins_model.sv
// far side model: external count clocks and capture pins
module ext_pins_model
	import timer_pkg::*;
(
	// clock
	input wire logic clk,
	// commands from the bench
	input wire logic [NUM_TIMERS-1:0] pulse_go,
	input wire logic [NUM_TIMERS*NUM_CAPS-1:0] cap_lvl,
	// pins towards the timers
	output logic [NUM_TIMERS-1:0] cnt_in,
	output logic [NUM_TIMERS*NUM_CAPS-1:0] cap_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div = 2'h0;
	logic [NUM_TIMERS-1:0] cnt_q = '0;
	logic [NUM_TIMERS*NUM_CAPS-1:0] cap_q = '0;

	assign cnt_in = cnt_q;
	assign cap_in = cap_q;

	// count clock stands still unless commanded
	always @(posedge clk) begin
		div <= div + 2'h1;
		if (div == 2'h3) begin
			cnt_q <= cnt_q ^ pulse_go;
		end
		cap_q <= cap_lvl;
	end
endmodule : ext_pins_model

// file: tb/timer_counter_match_capture_tb_top.sv
// self-checking bench for the match/capture timer block
module timer_counter_match_capture_tb_top
	import timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==================================================================
	// signals
	logic sys_clk, rst, ce, wr, rd, irq, s, cnt_prev;
	logic [7:0] addr, cap_in, cap_lvl, dma_req;
	logic [7:0] dma_seen = '0;
	logic [31:0] wdata, rdata, d, b, e;
	logic [3:0] cnt_in, pulse_go;
	logic [15:0] mat_out;
	int num_errors, num_checks, edges, n, x, mv, p;

	timer_counter_match_capture i_timer_counter_match_capture (
		.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CNT_IN(cnt_in), .CAP_IN(cap_in),
		.MAT_OUT(mat_out), .DMA_REQ(dma_req), .IRQ(irq));
	ext_pins_model i_ext_pins_model (.clk(sys_clk), .pulse_go(pulse_go),
		.cap_lvl(cap_lvl), .cnt_in(cnt_in), .cap_in(cap_in));

	always @(posedge sys_clk) begin
		dma_seen <= dma_seen | dma_req;
		cnt_prev <= cnt_in[2];
		if (cnt_in[2] === 1'b1 && cnt_prev === 1'b0) begin
			edges <= edges + 1;
		end
	end

	// ==================================================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [1:0] t, input logic [3:0] r,
		input logic [31:0] v);
		@(posedge sys_clk);
		addr <= {t, r, 2'h0};
		wdata <= v;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [1:0] t, input logic [3:0] r,
		output logic [31:0] v);
		@(posedge sys_clk);
		addr <= {t, r, 2'h0};
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [1:0] t, input logic [3:0] r,
		input logic [31:0] exp);
		logic [31:0] v;
		rd_reg(t, r, v);
		check($sformatf("reg %0d of timer %0d", r, t), v, exp);
	endtask : rd_chk

	task automatic wait_irq(output int cnt);
		cnt = 0;
		while (irq !== 1'b1 && cnt < 2000) begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
	endtask : wait_irq

	function automatic logic exp_pin(input logic [1:0] act, input logic st);
		case (act)
			ACT_LOW: return 1'b0;
			ACT_HIGH: return 1'b1;
			ACT_TOGGLE: return ~st;
			default: return st;
		endcase
	endfunction : exp_pin

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	// ==================================================================
	// clock, watchdog, tests
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		#200us;
		num_errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(97));
		{rst, ce, wr, rd} = 4'b1100;
		{addr, wdata, pulse_go, cap_lvl} = '0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		for (int t = 0; t < 4; t++)
			for (int r = 0; r < 16; r++)
				rd_chk(2'(t), 4'(r), RST_WORD);
		// each action on its own timer and channel, stop on match
		for (int a = 0; a < 4; a++) begin
			s = 1'($urandom);
			p = $urandom % 4;
			mv = 4 + $urandom % 16;
			wr_reg(2'(a), REG_PRESC, p);
			wr_reg(2'(a), 4'(REG_MATCH0 + a), mv);
			wr_reg(2'(a), REG_OUTCTL,
				(32'(s) << a) | ((3 - a) << (ACT_POS + 2 * a)));
			wr_reg(2'(a), REG_MCTL, 32'h5 << (3 * a));
			wr_reg(2'(a), REG_MASK, 32'h1 << a);
			wr_reg(2'(a), REG_DMACTL, (32'h1 << a) | 32'hc);
			wr_reg(2'(a), REG_CTRL, 32'h1);
			wait_irq(n);
			x = (mv + 1) * (p + 1);
			check("match time", 32'(n >= x - 1 && n <= x + 3), 32'h1);
			check("pin", 32'(mat_out[5 * a]), 32'(exp_pin(2'(3 - a), s)));
			rd_chk(2'(a), REG_COUNT, mv);
			check("dma", 32'(dma_seen[2 * a +: 2]), a < 2 ? 1 << a : 0);
			rd_chk(2'(a), REG_CTRL, 32'h0);
			rd_chk(2'(a), REG_STATUS, 32'h1 << a);
			wr_reg(2'(a), REG_STATUS, 32'h1 << a);
			wr_reg(2'(a), REG_MCTL, 32'h0);
			wr_reg(2'(a), REG_PCNT, 32'h0);
			#1;
			check("irq cleared", 32'(irq), 32'h0);
		end
		// continuous and reset matches, interrupt masked then unmasked
		wr_reg(0, REG_COUNT, 0);
		wr_reg(0, REG_PRESC, 0);
		wr_reg(0, REG_MATCH0, 2);
		wr_reg(0, 4'(REG_MATCH0 + 1), 6);
		wr_reg(0, REG_MCTL, 32'h19);
		wr_reg(0, REG_MASK, 0);
		wr_reg(0, REG_CTRL, 1);
		repeat (40) @(posedge sys_clk);
		#1;
		check("masked irq", 32'(irq), 32'h0);
		rd_chk(0, REG_STATUS, 32'h3);
		rd_chk(0, REG_CTRL, 32'h1);
		rd_reg(0, REG_COUNT, d);
		check("wrapped count", 32'(d <= 6), 32'h1);
		wr_reg(0, REG_MASK, 2);
		wait_irq(n);
		check("unmasked irq", 32'(n <= 2), 32'h1);
		wr_reg(0, REG_CTRL, 0);
		wr_reg(0, REG_MASK, 0);
		// capture: channel 0 on rise, channel 1 on fall
		wr_reg(1, REG_COUNT, 0);
		wr_reg(1, REG_PRESC, 0);
		wr_reg(1, REG_CAPCTL, 32'h35);
		wr_reg(1, REG_MASK, 32'h10);
		wr_reg(1, REG_CTRL, 1);
		rd_reg(1, REG_COUNT, b);
		cap_lvl[3:2] = 2'b11;
		repeat (8) @(posedge sys_clk);
		rd_reg(1, REG_COUNT, e);
		rd_reg(1, REG_CAP0, d);
		check("capture window", 32'(d > b && d < e), 32'h1);
		rd_chk(1, REG_STATUS, 32'h10);
		check("capture irq", 32'(irq), 32'h1);
		cap_lvl[3:2] = 2'b00;
		repeat (8) @(posedge sys_clk);
		rd_chk(1, REG_STATUS, 32'h30);
		rd_reg(1, 4'(REG_CAP0 + 1), e);
		check("second capture", 32'(e > d), 32'h1);
		// clock enable low freezes the running count
		rd_reg(1, REG_COUNT, b);
		@(posedge sys_clk);
		ce <= 1'b0;
		repeat (20) @(posedge sys_clk);
		ce <= 1'b1;
		rd_reg(1, REG_COUNT, e);
		check("frozen count", e, b + 32'h3);
		wr_reg(3, REG_CAP0, $urandom);
		rd_chk(3, REG_CAP0, 32'h0);
		// external count clock on timer 2
		wr_reg(2, REG_COUNT, 0);
		wr_reg(2, REG_PRESC, 0);
		wr_reg(2, REG_CTRL, 32'h5);
		pulse_go[2] <= 1'b1;
		repeat (40 + $urandom % 60) @(posedge sys_clk);
		pulse_go[2] <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rd_chk(2, REG_COUNT, 32'(edges));
		report_and_stop();
	end
endmodule : timer_counter_match_capture_tb_top
